// [cpfs_camera_pin_function_select.sv]
// Camera pad function selector with AHB-Lite register port
// ==========================================================================
// How it works
// [RQ1] Bits 14..11 pick camera or GPIO for pixclk, wen/field, vsync, hsync pads.
// [RQ2] Bit 10 routes all eight luma pads to camera or GPIO.
// [RQ3] Bit 9 routes chroma pads 0 and 1 together to camera or GPIO.
// [RQ4] Bit 8 routes chroma pads 2 and 3 together to camera or GPIO.
// [RQ5] Chroma pad 4 field 7:6: GPIO, camera, serial data-in 3, chip-select 2.
// [RQ6] Pads 5,6,7 fields: GPIO, camera, serial cs1/dout/clock; 3 reserved.
// [RQ7] Bits 31..15 read zero; fields read/write, reset zero, all pads GPIO.
// [RQ8] Upper bit writes ignored; reserved code 3 on pads 5..7 gives GPIO.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cpfs_consts.svh"

module cpfs_camera_pin_function_select (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Control pad selects: 1 camera, 0 GPIO
  output logic             pixelClockPadSelect,
  output logic             writeEnableFieldPadSelect,
  output logic             verticalSyncPadSelect,
  output logic             horizontalSyncPadSelect,
  // Data pad selects: 1 camera; 0 GPIO, or serial port on chroma 4..7
  output logic      [7:0]  lumaPadCamera,
  output logic      [7:0]  chromaPadCamera,
  // Serial port pad claims
  output logic             serialPortThirdDataIn,
  output logic             serialPortSecondChipSelect,
  output logic             serialPortFirstChipSelect,
  output logic             serialPortDataOut,
  output logic             serialPortClock,
  // Pads left to GPIO
  output logic      [21:0] gpioPadOwned
);

  // ========================================================================
  // Bus decode
  logic [`CPFS_SELECT_WIDTH-1:0] selectQ;
  logic [`CPFS_SELECT_WIDTH-1:0] selectD;
  logic                          wrPendQ;
  logic                          rdHitQ;
  logic [31:0]                   hrdataQ;
  wire  phaseValid = hsel && hready && (htrans == `CPFS_HTRANS_NONSEQ);
  wire  addrHit    = (haddr[`CPFS_ADDR_BITS-1:0] == `CPFS_SELECT_OFFSET);
  wire  wordSize   = (hsize == `CPFS_HSIZE_WORD);
  wire  takeWrite  = phaseValid && hwrite && addrHit && wordSize;
  wire  takeRead   = phaseValid && !hwrite;
  wire  doWrite    = wrPendQ;

  // Upper bits dropped on write
  assign selectD = doWrite ? hwdata[`CPFS_SELECT_WIDTH-1:0] : selectQ; // RQ8

  // ========================================================================
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selectQ <= `CPFS_SELECT_RESET; // RQ7
      wrPendQ <= 1'b0;
    end else begin
      selectQ <= selectD;
      wrPendQ <= takeWrite;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdHitQ <= 1'b0;
    end else begin
      rdHitQ <= takeRead;
    end
  end

  // Reserved and unmapped read as zero; a write in its data phase is forwarded
  wire [31:0] readWord = {{(32-`CPFS_SELECT_WIDTH){1'b0}}, selectD}; // RQ7
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdataQ <= 32'h0000_0000;
    end else begin
      hrdataQ <= (takeRead && addrHit) ? readWord : 32'h0000_0000;
    end
  end

  assign hrdata    = hrdataQ;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ========================================================================
  // Pad function decode
  wire cpfs_pkg::cpfs_fn_t fn4 = cpfs_pkg::cpfs_fn_t'(selectQ[`CPFS_CHROMA4_LSB +: 2]);
  wire cpfs_pkg::cpfs_fn_t fn5 = cpfs_pkg::cpfs_fn_t'(selectQ[`CPFS_CHROMA5_LSB +: 2]);
  wire cpfs_pkg::cpfs_fn_t fn6 = cpfs_pkg::cpfs_fn_t'(selectQ[`CPFS_CHROMA6_LSB +: 2]);
  wire cpfs_pkg::cpfs_fn_t fn7 = cpfs_pkg::cpfs_fn_t'(selectQ[`CPFS_CHROMA7_LSB +: 2]);

  assign pixelClockPadSelect       = selectQ[`CPFS_PIXCLK_BIT];    // RQ1
  assign writeEnableFieldPadSelect = selectQ[`CPFS_WEN_FIELD_BIT]; // RQ1
  assign verticalSyncPadSelect     = selectQ[`CPFS_VSYNC_BIT];     // RQ1
  assign horizontalSyncPadSelect   = selectQ[`CPFS_HSYNC_BIT];     // RQ1
  assign lumaPadCamera = {8{selectQ[`CPFS_LUMA_BIT]}}; // RQ2

  assign chromaPadCamera[1:0] = {2{selectQ[`CPFS_CHROMA_LOW_BIT]}}; // RQ3
  assign chromaPadCamera[3:2] = {2{selectQ[`CPFS_CHROMA_SEC_BIT]}}; // RQ4
  assign chromaPadCamera[4]   = (fn4 == cpfs_pkg::CPFS_FN_CAMERA); // RQ5
  assign chromaPadCamera[5]   = (fn5 == cpfs_pkg::CPFS_FN_CAMERA); // RQ6
  assign chromaPadCamera[6]   = (fn6 == cpfs_pkg::CPFS_FN_CAMERA); // RQ6
  assign chromaPadCamera[7]   = (fn7 == cpfs_pkg::CPFS_FN_CAMERA); // RQ6

  // ========================================================================
  // Serial port claims
  assign serialPortThirdDataIn      = (fn4 == cpfs_pkg::CPFS_FN_SERIAL); // RQ5
  assign serialPortSecondChipSelect = (fn4 == cpfs_pkg::CPFS_FN_ALT);    // RQ5
  assign serialPortFirstChipSelect  = (fn5 == cpfs_pkg::CPFS_FN_SERIAL); // RQ6
  assign serialPortDataOut          = (fn6 == cpfs_pkg::CPFS_FN_SERIAL); // RQ6
  assign serialPortClock            = (fn7 == cpfs_pkg::CPFS_FN_SERIAL); // RQ6

  // ========================================================================
  // GPIO ownership
  // GPIO order: pixclk, wen, vsync, hsync, luma 0..7, chroma 0..7 (bits 0..19)
  // Reserved code 3 on pads 5..7 leaves the pad on GPIO
  wire pad5Gpio = (fn5 == cpfs_pkg::CPFS_FN_GPIO) || (fn5 == cpfs_pkg::CPFS_FN_ALT); // RQ8
  wire pad6Gpio = (fn6 == cpfs_pkg::CPFS_FN_GPIO) || (fn6 == cpfs_pkg::CPFS_FN_ALT); // RQ8
  wire pad7Gpio = (fn7 == cpfs_pkg::CPFS_FN_GPIO) || (fn7 == cpfs_pkg::CPFS_FN_ALT); // RQ8
  assign gpioPadOwned = {2'b00,
                         pad7Gpio,
                         pad6Gpio,
                         pad5Gpio,
                         (fn4 == cpfs_pkg::CPFS_FN_GPIO),
                         ~chromaPadCamera[3:0],
                         ~lumaPadCamera,
                         ~horizontalSyncPadSelect,
                         ~verticalSyncPadSelect,
                         ~writeEnableFieldPadSelect,
                         ~pixelClockPadSelect};

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  write_lands_a: assert property (takeWrite |=> ##1 selectQ == $past(hwdata[14:0])) // RQ7
    else $error("select register did not take written data");
  upper_zero_a: assert property (rdHitQ |-> hrdata[31:15] == 17'h00000) // RQ7
    else $error("reserved bits read non-zero");
  read_back_a: assert property ( // RQ7
    takeRead && addrHit |=> hrdata == {17'h00000, $past(selectD)})
    else $error("read data mismatch");
  read_idle_a: assert property ( // RQ7
    !(takeRead && addrHit) |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  bus_okay_a: assert property (hreadyout && !hresp) // RQ7
    else $error("bus response not ready and okay");
  refused_write_a: assert property ( // RQ8
    phaseValid && hwrite && !takeWrite |=> ##1 $stable(selectQ))
    else $error("refused write changed select register");
  sync_pads_a: assert property ( // RQ1
    pixelClockPadSelect == selectQ[14] && horizontalSyncPadSelect == selectQ[11])
    else $error("control pad select wrong");
  wen_vsync_a: assert property ( // RQ1
    writeEnableFieldPadSelect == selectQ[13] && verticalSyncPadSelect == selectQ[12])
    else $error("field or vsync pad select wrong");
  luma_all_a: assert property (lumaPadCamera == {8{selectQ[10]}}) // RQ2
    else $error("luma pads not together");
  chroma_pairs_a: assert property ( // RQ3 RQ4
    chromaPadCamera[1] == chromaPadCamera[0] && chromaPadCamera[3] == selectQ[8])
    else $error("chroma pair select wrong");
  chroma_low_a: assert property ( // RQ3 RQ4
    chromaPadCamera[0] == selectQ[9] && chromaPadCamera[2] == chromaPadCamera[3])
    else $error("chroma low pair select wrong");
  pad4_onehot_a: assert property ( // RQ5
    $onehot({chromaPadCamera[4], serialPortThirdDataIn, serialPortSecondChipSelect,
             gpioPadOwned[16]}))
    else $error("pad 4 function not unique");
  pad4_codes_a: assert property ( // RQ5
    chromaPadCamera[4] == (selectQ[7:6] == 2'h1) &&
    serialPortThirdDataIn == (selectQ[7:6] == 2'h2) &&
    serialPortSecondChipSelect == (selectQ[7:6] == 2'h3))
    else $error("pad 4 function does not follow its field");
  pad_serial_a: assert property ( // RQ6
    serialPortFirstChipSelect == (selectQ[5:4] == 2'h2) &&
    serialPortDataOut == (selectQ[3:2] == 2'h2) &&
    serialPortClock == (selectQ[1:0] == 2'h2))
    else $error("serial claim does not follow its field");
  pad_camera_a: assert property ( // RQ6
    chromaPadCamera[5] == (selectQ[5:4] == 2'h1) &&
    chromaPadCamera[6] == (selectQ[3:2] == 2'h1) &&
    chromaPadCamera[7] == (selectQ[1:0] == 2'h1))
    else $error("chroma camera select does not follow its field");
  pad5_onehot_a: assert property ( // RQ6
    $onehot({chromaPadCamera[5], serialPortFirstChipSelect, gpioPadOwned[17]}))
    else $error("pad 5 function not unique");
  pad6_onehot_a: assert property ( // RQ6
    $onehot({chromaPadCamera[6], serialPortDataOut, gpioPadOwned[18]}))
    else $error("pad 6 function not unique");
  pad7_clock_a: assert property ( // RQ6
    serialPortClock |-> !chromaPadCamera[7] && !gpioPadOwned[19])
    else $error("pad 7 claimed twice");
  pad7_onehot_a: assert property ( // RQ6
    $onehot({chromaPadCamera[7], serialPortClock, gpioPadOwned[19]}))
    else $error("pad 7 function not unique");
  pad_reserved_a: assert property ( // RQ8
    (selectQ[5:4] != 2'h3 || gpioPadOwned[17]) &&
    (selectQ[3:2] != 2'h3 || gpioPadOwned[18]) &&
    (selectQ[1:0] != 2'h3 || gpioPadOwned[19]))
    else $error("reserved code did not leave pad on GPIO");
  spare_gpio_a: assert property (gpioPadOwned[21:20] == 2'b00) // RQ7
    else $error("spare GPIO bits not zero");
  stable_noWrite_a: assert property (!wrPendQ |=> $stable(selectQ)) // RQ8
    else $error("select changed without write");

  // ========================================================================
  // Cover points
  luma_on_c: cover property (takeWrite ##2 lumaPadCamera == 8'hff);
  spi_clk_c: cover property (serialPortClock);
  cs2_c: cover property (serialPortSecondChipSelect);
  read_c: cover property (rdHitQ && hrdata != 32'h0000_0000);
  reserved_c: cover property (selectQ[5:4] == 2'h3 && gpioPadOwned[17]);

endmodule : cpfs_camera_pin_function_select

`default_nettype wire

// [cpfs_consts.svh]
// Constants for the camera pin function select block
`ifndef CPFS_CONSTS_SVH
`define CPFS_CONSTS_SVH

// ==========================================================================
// Register map
`define CPFS_SELECT_OFFSET    12'h000
`define CPFS_ADDR_BITS        12
`define CPFS_SELECT_RESET     15'h0000
`define CPFS_SELECT_WIDTH     15

// ==========================================================================
// Field positions
`define CPFS_PIXCLK_BIT       14
`define CPFS_WEN_FIELD_BIT    13
`define CPFS_VSYNC_BIT        12
`define CPFS_HSYNC_BIT        11
`define CPFS_LUMA_BIT         10
`define CPFS_CHROMA_LOW_BIT   9
`define CPFS_CHROMA_SEC_BIT   8
`define CPFS_CHROMA4_LSB      6
`define CPFS_CHROMA5_LSB      4
`define CPFS_CHROMA6_LSB      2
`define CPFS_CHROMA7_LSB      0

// ==========================================================================
// AHB encodings
`define CPFS_HTRANS_NONSEQ    2'h2
`define CPFS_HSIZE_WORD       3'h2

`endif

// [cpfs_pkg.sv]
// Types for the camera pin function select block
`default_nettype none
package cpfs_pkg;

  // ========================================================================
  // Per-pad function of a two-bit chroma field
  typedef enum logic [1:0] {
    CPFS_FN_GPIO   = 2'h0,
    CPFS_FN_CAMERA = 2'h1,
    CPFS_FN_SERIAL = 2'h2,
    CPFS_FN_ALT    = 2'h3
  } cpfs_fn_t;

endpackage : cpfs_pkg

`default_nettype wire

// [cpfs_sensor_model.sv]
// Behavioural image sensor that drives the pixel clock pad
`timescale 1ns/1ps
`default_nettype none
module cpfs_sensor_model (
  // Pad ownership
  input  wire logic padCamera,
  // Sensor pixel clock
  output logic      pixelClock
);
  // Clock stands low unless the pad is handed to the camera
  initial pixelClock = 1'b0;
  always #7 pixelClock = padCamera ? ~pixelClock : 1'b0;
endmodule : cpfs_sensor_model
`default_nettype wire

// [cpfs_tb.sv]
// Self-checking bench for the camera pin function select block
`timescale 1ns/1ps
`default_nettype none
`include "cpfs_consts.svh"
module tb;
  // ========================================================================
  // Signals
  logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, pcs, wes, vss, hss, sdi3, cs2, cs1, sdo, sck, sensorClk;
  logic [7:0]  luma, chroma;
  logic [21:0] gpio;
  int          n_mismatch = 0, n_compared = 0;
  int          nPixelEdges = 0, pixelBase = 0;
  wire  [46:0] pins = {pcs, wes, vss, hss, luma, chroma, sdi3, cs2, cs1, sdo, sck, gpio};
  logic [63:0] rows [21] = '{64'hffff8000_00000000, 64'h4000_00004000, 64'h2000_00002000,
    64'h1000_00001000, 64'h0800_00000800, 64'h0400_00000400, 64'h0200_00000200,
    64'h0100_00000100, 64'h40_00000040, 64'h80_00000080, 64'hc0_000000c0, 64'h10_00000010,
    64'h20_00000020, 64'h30_00000030, 64'h4_00000004, 64'h8_00000008, 64'hc_0000000c,
    64'h1_00000001, 64'h2_00000002, 64'h3_00000003, 64'hffffffff_00007fff};

  always #2.5 clock = ~clock;
  always @(posedge sensorClk) nPixelEdges++;

  cpfs_camera_pin_function_select dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .pixelClockPadSelect(pcs), .writeEnableFieldPadSelect(wes), .verticalSyncPadSelect(vss),
    .horizontalSyncPadSelect(hss), .lumaPadCamera(luma), .chromaPadCamera(chroma),
    .serialPortThirdDataIn(sdi3), .serialPortSecondChipSelect(cs2),
    .serialPortFirstChipSelect(cs1), .serialPortDataOut(sdo), .serialPortClock(sck),
    .gpioPadOwned(gpio));
  cpfs_sensor_model sensor (.padCamera(pcs), .pixelClock(sensorClk));

  // ========================================================================
  // Expected pad state from a register value
  function automatic logic [46:0] pads(input logic [14:0] r);
    logic [7:0]  c;
    logic [4:0]  s;
    logic [21:0] g;
    c = {r[1:0] == 2'h1, r[3:2] == 2'h1, r[5:4] == 2'h1, r[7:6] == 2'h1, {2{r[8]}}, {2{r[9]}}};
    s = {r[7:6] == 2'h2, r[7:6] == 2'h3, r[5:4] == 2'h2, r[3:2] == 2'h2, r[1:0] == 2'h2};
    g = {2'h0, r[1:0] == 2'h0 || r[1:0] == 2'h3, r[3:2] == 2'h0 || r[3:2] == 2'h3,
      r[5:4] == 2'h0 || r[5:4] == 2'h3, r[7:6] == 2'h0, ~c[3:0], ~{8{r[10]}},
      ~r[11], ~r[12], ~r[13], ~r[14]};
    return {r[14:11], {8{r[10]}}, c, s, g};
  endfunction : pads

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One AHB-Lite single transfer, result of a read left in q
  task automatic bus(input logic w, input logic [2:0] sz, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= `CPFS_HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ========================================================================
  // Tests
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, `CPFS_HSIZE_WORD, 32'h0, 32'h0);
    chk("reset value", q, 64'h0);
    chk("reset pads", pins, pads(15'h0));
    chk("response", {hreadyout, hresp}, 64'h2);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, `CPFS_HSIZE_WORD, 32'h0, rows[i][63:32]);
      bus(1'b0, `CPFS_HSIZE_WORD, 32'h0, 32'h0);
      chk("readback", q, rows[i][31:0]);
      chk("pads", pins, pads(rows[i][14:0]));
    end
    $display("table test done");
    bus(1'b1, `CPFS_HSIZE_WORD, 32'h0, 32'h1234);
    bus(1'b1, `CPFS_HSIZE_WORD, 32'h4, 32'h7fff);
    bus(1'b1, 3'h0, 32'h0, 32'h7fff);
    bus(1'b0, `CPFS_HSIZE_WORD, 32'h4, 32'h0);
    chk("unmapped read", q, 64'h0);
    bus(1'b0, `CPFS_HSIZE_WORD, 32'h0, 32'h0);
    chk("refused writes", q, 64'h1234);
    chk("refused pads", pins, pads(15'h1234));
    $display("refusal test done");
    pixelBase = nPixelEdges;
    repeat (10) @(posedge clock);
    chk("pixel clock idle", nPixelEdges - pixelBase, 64'h0);
    bus(1'b1, `CPFS_HSIZE_WORD, 32'h0, 32'h4000);
    pixelBase = nPixelEdges;
    repeat (10) @(posedge clock);
    chk("pixel clock runs", nPixelEdges > pixelBase, 64'h1);
    $display("sensor clock test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk("pads in reset", pins, pads(15'h0));
    chk("read data in reset", hrdata, 64'h0);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, `CPFS_HSIZE_WORD, 32'h0, 32'h0);
    chk("second reset", q, 64'h0);
    chk("second reset pads", pins, pads(15'h0));
    $display("second reset test done");
    report_and_stop();
  end

  initial begin
    #10000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
